// file: core/tx_refclk_switch_handshake.sv
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "tx_refclk_switch_consts.svh"

// Contract
// [RULE1] switching allowed unless standard-definition mode set
// [RULE2] integrator picks alternate PLL or dual-input PLL
// [RULE3] controller feeds select to core and reconfigurator
// [RULE4] select 0 primary, select 1 alternate
// [RULE5] controller raises request to start switch
// [RULE6] request with select change or one later
// [RULE7] request held high until reconfiguration done
// [RULE8] done indication driven high when reconfiguration finishes
// [RULE9] controller drops request once done seen
// [RULE10] controller asserts transmitter reset after dropping request
// [RULE11] new rate commits only after reset pulse
// [RULE12] transmit clock locks to the selected reference
// [RULE13] select back to 0 first: stays primary
// [RULE14] transmitter reset active high, core-clock synchronous
// [RULE15] receiver reset active high, level sensitive
// [RULE16] powerdown input resets the TX PLLs
// [RULE17] powerdown output resets selected PLL only; code also holds the in-use PLL on the powerdown bit or txRst
// [RULE18] merged instances share powerdown and reference source
// [RULE19] busy handshake ignores select and new requests
module tx_refclk_switch_handshake #(
   parameter int NUM_PLLS        = 1,
   parameter int CNT_W           = 8,
   parameter int RECONFIG_CYCLES = `RECONFIG_CYCLES,
   parameter int LOCK_CYCLES     = `LOCK_CYCLES
) (
   input  wire logic                ref_clk,
   input  wire logic                rstn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output var  logic [31:0]         prdata,
   output var  logic                pready,
   output var  logic                pslverr,
   input  wire logic                pllSel,
   input  wire logic                startReconfig,
   output var  logic                reconfigDone,
   input  wire logic                txRst,
   input  wire logic                rxRst,
   input  wire logic [NUM_PLLS-1:0] pllPowerdownIn,
   output var  logic [NUM_PLLS-1:0] pllPowerdownOut,
   output var  logic                txRefSel,
   output var  logic                txClkLocked,
   output var  logic                rxInReset
);

   tx_refclk_switch_pkg::switch_state_type state_r;

   logic [1:0]        ctrl_r;
   logic              pending_r;
   logic              fail_r;
   logic              selPrev_r;
   logic [CNT_W-1:0]  reconfCnt_r;
   logic [CNT_W-1:0]  lockCnt_r [NUM_PLLS];
   logic [NUM_PLLS-1:0] pllLocked;
   logic              accept;
   logic              apbAccess;
   logic              ctrlHit;
   logic              statusHit;
   logic              failSet;

   // with one PLL both references feed its two inputs, so index stays 0
   function automatic int pllIndex(input logic sel);
      return (NUM_PLLS > 1) ? int'(sel) : 0;
   endfunction

   // new requests only from idle, and never in standard-definition mode
   assign accept = (state_r == tx_refclk_switch_pkg::SW_IDLE) &&
                   startReconfig && !ctrl_r[`CTRL_SD_BIT]; // see [RULE1] [RULE19]

   // a request is taken in the first cycle after select fell from alternate to primary
   assign failSet = accept && selPrev_r == `REF_ALT &&
                    pllSel == `REF_PRIMARY; // see [RULE13]

   assign apbAccess = psel && penable && pready;
   assign ctrlHit   = paddr == `REG_CTRL_ADDR;
   assign statusHit = paddr == `REG_STATUS_ADDR;

   // one wait state keeps read data registered
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         prdata  <= 32'h0000_0000;
         pslverr <= !(ctrlHit || statusHit);
         if (!pwrite && ctrlHit) begin
            prdata[1:0] <= ctrl_r;
         end else if (!pwrite && statusHit) begin
            prdata[`ST_ACTIVE_BIT]  <= txRefSel;
            prdata[`ST_PENDING_BIT] <= pending_r;
            prdata[`ST_BUSY_BIT]    <=
               state_r != tx_refclk_switch_pkg::SW_IDLE;
            prdata[`ST_LOCKED_BIT]  <= txClkLocked;
            prdata[`ST_FAIL_BIT]    <= fail_r;
            prdata[`ST_RXRST_BIT]   <= rxInReset;
         end
      end else begin
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= `CTRL_RESET;
      end else if (apbAccess && pwrite && ctrlHit) begin
         ctrl_r <= pwdata[1:0];
      end
   end

   // set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fail_r <= 1'b0;
      end else if (failSet) begin
         fail_r <= 1'b1;
      end else if (apbAccess && pwrite && statusHit &&
                   pwdata[`ST_FAIL_BIT]) begin
         fail_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         selPrev_r <= `REF_PRIMARY;
      end else begin
         selPrev_r <= pllSel;
      end
   end

   // handshake sequencer
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_r      <= tx_refclk_switch_pkg::SW_IDLE;
         pending_r    <= `REF_PRIMARY;
         reconfCnt_r  <= '0;
         reconfigDone <= 1'b0;
      end else begin
         case (state_r)
            tx_refclk_switch_pkg::SW_IDLE: begin
               if (accept) begin
                  pending_r   <= pllSel; // see [RULE4] [RULE13]
                  reconfCnt_r <= '0;
                  state_r     <= tx_refclk_switch_pkg::SW_RECONF;
               end
            end
            tx_refclk_switch_pkg::SW_RECONF: begin
               reconfCnt_r <= reconfCnt_r + CNT_W'(1);
               if (reconfCnt_r == CNT_W'(RECONFIG_CYCLES - 1)) begin
                  reconfigDone <= 1'b1; // see [RULE8]
                  state_r      <= tx_refclk_switch_pkg::SW_DONE;
               end
            end
            tx_refclk_switch_pkg::SW_DONE: begin
               if (!startReconfig) begin
                  reconfigDone <= 1'b0;
                  state_r      <= tx_refclk_switch_pkg::SW_WAIT_RST_HI;
               end
            end
            tx_refclk_switch_pkg::SW_WAIT_RST_HI: begin
               if (txRst) begin
                  state_r <= tx_refclk_switch_pkg::SW_WAIT_RST_LO;
               end
            end
            tx_refclk_switch_pkg::SW_WAIT_RST_LO: begin
               if (!txRst) begin
                  state_r <= tx_refclk_switch_pkg::SW_IDLE;
               end
            end
            default: begin
               state_r      <= tx_refclk_switch_pkg::SW_IDLE;
               reconfigDone <= 1'b0;
            end
         endcase
      end
   end

   // the rate in use moves only on the falling reset edge
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         txRefSel <= `REF_PRIMARY;
      end else if (state_r == tx_refclk_switch_pkg::SW_WAIT_RST_LO &&
                   !txRst) begin
         txRefSel <= pending_r; // see [RULE11]
      end
   end

   // PLL lock counters, cleared by the powerdown input
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_PLLS; i++) begin
            lockCnt_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_PLLS; i++) begin
            if (pllPowerdownIn[i]) begin
               lockCnt_r[i] <= '0; // see [RULE16]
            end else if (lockCnt_r[i] != CNT_W'(LOCK_CYCLES)) begin
               lockCnt_r[i] <= lockCnt_r[i] + CNT_W'(1);
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_PLLS; i++) begin
         pllLocked[i] = lockCnt_r[i] == CNT_W'(LOCK_CYCLES);
      end
   end

   // only the PLL being retuned or in use is held down
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pllPowerdownOut <= '0;
      end else begin
         for (int i = 0; i < NUM_PLLS; i++) begin
            pllPowerdownOut[i] <=
               (state_r == tx_refclk_switch_pkg::SW_RECONF &&
                i == pllIndex(pending_r)) ||
               ((ctrl_r[`CTRL_PD_BIT] || txRst) &&
                i == pllIndex(txRefSel)); // see [RULE17]
         end
      end
   end

   // reset is taken as a plain synchronous level on the core clock
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         txClkLocked <= 1'b0;
      end else begin
         txClkLocked <= pllLocked[pllIndex(txRefSel)] &&
                        !txRst; // see [RULE12] [RULE14]
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rxInReset <= 1'b0;
      end else begin
         rxInReset <= rxRst; // see [RULE15]
      end
   end

   // done is registered, so it is seen one edge after the last count
   localparam int DONE_LAG = RECONFIG_CYCLES + 1;

   sequence seqAccept;
      accept;
   endsequence

   sequence seqDoneAfterReconf;
      !reconfigDone [*1] ##[DONE_LAG:DONE_LAG] reconfigDone;
   endsequence

   AST_DONE_TIMING: assert property ( // see [RULE8]
      @(posedge ref_clk) disable iff (!rstn)
      seqAccept |-> seqDoneAfterReconf)
      else $error("done not raised after reconfiguration time");

   AST_DONE_HOLD: assert property ( // see [RULE8]
      @(posedge ref_clk) disable iff (!rstn)
      reconfigDone && startReconfig |=> reconfigDone)
      else $error("done dropped while request still high");

   AST_DONE_RELEASE: assert property ( // see [RULE8]
      @(posedge ref_clk) disable iff (!rstn)
      reconfigDone && !startReconfig |=> !reconfigDone)
      else $error("done held after request dropped");

   AST_COMMIT_AFTER_RESET: assert property ( // see [RULE11]
      @(posedge ref_clk) disable iff (!rstn)
      $changed(txRefSel) |-> $past(txRst, 2) && !$past(txRst))
      else $error("rate changed without a reset pulse");

   AST_FAIL_STAYS_PRIMARY: assert property ( // see [RULE13]
      @(posedge ref_clk) disable iff (!rstn)
      failSet |=> fail_r && pending_r == `REF_PRIMARY)
      else $error("failed switch did not stay on primary");

   AST_PD_IN_UNLOCKS: assert property ( // see [RULE16]
      @(posedge ref_clk) disable iff (!rstn)
      // a commit on the next edge hands the lock report to the other PLL
      pllPowerdownIn[pllIndex(txRefSel)] && $stable(txRefSel)
      |=> ($changed(txRefSel) or ##1 !txClkLocked))
      else $error("clock reported locked during powerdown");

   AST_PD_OUT_TARGET: assert property ( // see [RULE17]
      @(posedge ref_clk) disable iff (!rstn)
      state_r == tx_refclk_switch_pkg::SW_RECONF
      |=> pllPowerdownOut[pllIndex($past(pending_r))])
      else $error("target PLL not held during reconfiguration");

   AST_BUSY_IGNORES_SEL: assert property ( // see [RULE19]
      @(posedge ref_clk) disable iff (!rstn)
      state_r != tx_refclk_switch_pkg::SW_IDLE |=> $stable(pending_r))
      else $error("pending select changed while busy");

   AST_SD_NO_SWITCH: assert property ( // see [RULE1]
      @(posedge ref_clk) disable iff (!rstn)
      state_r == tx_refclk_switch_pkg::SW_IDLE && ctrl_r[`CTRL_SD_BIT]
      |=> state_r == tx_refclk_switch_pkg::SW_IDLE)
      else $error("switch started in standard-definition mode");

   AST_RX_RESET_LEVEL: assert property ( // see [RULE15]
      @(posedge ref_clk) disable iff (!rstn)
      rxRst [*2] |-> rxInReset)
      else $error("receiver reset level not reflected");

endmodule
`default_nettype wire

// file: inc/tx_refclk_switch_consts.svh
`ifndef TX_REFCLK_SWITCH_CONSTS_SVH
`define TX_REFCLK_SWITCH_CONSTS_SVH

// register byte addresses
`define REG_CTRL_ADDR     12'h000
`define REG_STATUS_ADDR   12'h004

// control register fields
`define CTRL_PD_BIT       0
`define CTRL_SD_BIT       1
`define CTRL_RESET        2'h0

// status register fields
`define ST_ACTIVE_BIT     0
`define ST_PENDING_BIT    1
`define ST_BUSY_BIT       2
`define ST_LOCKED_BIT     3
`define ST_FAIL_BIT       4
`define ST_RXRST_BIT      5

// reference clock select encoding
`define REF_PRIMARY       1'b0
`define REF_ALT           1'b1

// default cycle counts
`define RECONFIG_CYCLES   8
`define LOCK_CYCLES       16

`endif

// file: inc/tx_refclk_switch_pkg.sv
package tx_refclk_switch_pkg;

   typedef enum logic [2:0] {
      SW_IDLE,
      SW_RECONF,
      SW_DONE,
      SW_WAIT_RST_HI,
      SW_WAIT_RST_LO
   } switch_state_type;

endpackage

// file: verification/reconfig_partner.sv
`timescale 1ns/1ns
`default_nettype none
// stands in for the user switch controller and the two tx plls
module reconfig_partner (
   input  wire logic       ref_clk,
   input  wire logic       reconfigDone,
   input  wire logic       txRefSel,
   input  wire logic [1:0] pllPowerdownOut,
   input  wire logic       extPd,
   output var  logic       pllSel,
   output var  logic       startReconfig,
   output var  logic       txRst,
   output var  logic [1:0] pllPowerdownIn,
   output var  logic       pdSeen,
   output var  logic       held
);
   // loopback; extPd plays a merged master instance's powerdown
   // two plls, one per reference
   assign pllPowerdownIn = pllPowerdownOut | {2{extPd}};

   initial begin
      pllSel = 1'b0;
      startReconfig = 1'b0;
      txRst = 1'b0;
      pdSeen = 1'b0;
      held = 1'b0;
   end

   // glitch flips select to 1 for a cycle first; wobble misbehaves
   // while busy, which the block must ignore
   task automatic switch_to(input logic sel, input logic late,
                            input logic glitch, input logic wobble,
                            output int n);
      n = 0;
      pdSeen = 1'b0;
      if (glitch) begin
         pllSel <= 1'b1;
         @(posedge ref_clk);
      end
      pllSel <= sel;
      if (late)
         @(posedge ref_clk);
      startReconfig <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         pdSeen |= pllPowerdownOut[sel];
         // select is settled again in the last cycle of the wait
         if (wobble)
            pllSel <= (reconfigDone === 1'b1 || n >= 40) ? sel : ~sel;
      end while (reconfigDone !== 1'b1 && n < 40);
      startReconfig <= 1'b0;
      @(posedge ref_clk);
      txRst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      held = txRefSel;
      txRst <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// file: verification/test_tx_refclk_switch_handshake.sv
`timescale 1ns/1ns
`default_nettype none
`include "tx_refclk_switch_consts.svh"
module test_tx_refclk_switch_handshake;
   localparam int RC = 2;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        rxRst = 1'b0;
   logic        extPd = 1'b0;
   logic [31:0] prdata, q;
   logic        pready, pslverr, err, pllSel, startReconfig, reconfigDone;
   logic        txRst, txRefSel, txClkLocked, rxInReset, pdSeen, held;
   logic [1:0]  pdIn, pdOut;
   int          fail_count = 0;
   int          compares = 0;
   int          n;

   always #20 ref_clk = ~ref_clk;

   tx_refclk_switch_handshake #(.NUM_PLLS(2), .RECONFIG_CYCLES(RC),
      .LOCK_CYCLES(4)) uut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pllSel(pllSel),
      .startReconfig(startReconfig), .reconfigDone(reconfigDone),
      .txRst(txRst), .rxRst(rxRst), .pllPowerdownIn(pdIn),
      .pllPowerdownOut(pdOut), .txRefSel(txRefSel),
      .txClkLocked(txClkLocked), .rxInReset(rxInReset));

   reconfig_partner drv (.ref_clk(ref_clk), .reconfigDone(reconfigDone),
      .txRefSel(txRefSel), .pllPowerdownOut(pdOut), .extPd(extPd),
      .pllSel(pllSel), .startReconfig(startReconfig), .txRst(txRst),
      .pllPowerdownIn(pdIn), .pdSeen(pdSeen), .held(held));

   task automatic stop_test();
      if (fail_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("[ERR] %s exp %h got %h", nm, e, g);
         fail_count++;
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         fail_count++;
         stop_test();
      end
      @(posedge ref_clk);
   endtask

   task automatic lock_is(input logic e);
      int k;
      k = 0;
      while (txClkLocked !== e && k < 40) begin
         @(posedge ref_clk);
         k++;
      end
      chk("locked", {31'h0, e}, {31'h0, txClkLocked});
   endtask

   // whole status word; busy must read 0 once a switch is over
   task automatic status_is(input logic [31:0] e);
      apb(1'b0, `REG_STATUS_ADDR, 32'h0);
      chk("status", e, q);
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      apb(1'b0, `REG_CTRL_ADDR, 32'h0);
      chk("ctrl reset", 32'h0, q);
      apb(1'b1, `REG_CTRL_ADDR, 32'hffffffff);
      apb(1'b0, `REG_CTRL_ADDR, 32'h0);
      chk("ctrl rw", 32'h3, q);
      drv.switch_to(1'b1, 1'b0, 1'b0, 1'b0, n);
      chk("sd ignored", 32'h28, n);
      chk("sd ref", 32'h0, {31'h0, txRefSel});
      apb(1'b1, `REG_CTRL_ADDR, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, q);
      lock_is(1'b1);
      status_is(32'h08);
      // the take is the first counted edge, done follows RC+1 edges later
      drv.switch_to(1'b1, 1'b0, 1'b0, 1'b1, n);
      chk("done latency", RC + 2, n);
      chk("pll reset seen", 32'h1, {31'h0, pdSeen});
      chk("ref before release", 32'h0, {31'h0, held});
      chk("ref alt", 32'h1, {31'h0, txRefSel});
      lock_is(1'b1);
      status_is(32'h0b);
      drv.switch_to(1'b0, 1'b1, 1'b0, 1'b0, n);
      chk("late latency", RC + 2, n);
      chk("ref primary", 32'h0, {31'h0, txRefSel});
      drv.switch_to(1'b0, 1'b0, 1'b1, 1'b0, n);
      chk("glitch ref", 32'h0, {31'h0, txRefSel});
      lock_is(1'b1);
      status_is(32'h18);
      apb(1'b1, `REG_STATUS_ADDR, 32'h10);
      status_is(32'h08);
      apb(1'b1, `REG_CTRL_ADDR, 32'h1);
      lock_is(1'b0);
      chk("pd out", 32'h1, {30'h0, pdOut});
      apb(1'b1, `REG_CTRL_ADDR, 32'h0);
      lock_is(1'b1);
      extPd <= 1'b1;
      lock_is(1'b0);
      extPd <= 1'b0;
      lock_is(1'b1);
      rxRst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk("rx reset", 32'h1, {31'h0, rxInReset});
      status_is(32'h28);
      rxRst <= 1'b0;
      stop_test();
   end
endmodule
`default_nettype wire
